// ==== logic/tuner_cpu_sequencer_timer.v ====
// Program sequencer, stack, data memory map and timer flag of the tuning controller
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "tuner_seq_defines.vh"
module tuner_cpu_sequencer_timer #(
  parameter TICK_CYCLES = `TIMER_TICK_CYC
) (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  input  wire        chip_enable_pin_i,
  input  wire        int_req_i,
  input  wire [15:0] prog_data_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  output reg  [10:0] prog_addr_o,
  output reg         int_ack_o,
  output reg  [16:0] pll_divide_o,
  output reg  [3:0]  pll_ref_sel_o,
  output reg         pll_load_o,
  output reg  [1:0]  port_a_dir_o,
  output reg         port_b_out_en_o,
  output reg         timer_flag_o,
  output reg         halted_o
);
  localparam S_ADDR = 2'd0;
  localparam S_DEC  = 2'd1;
  localparam S_EXEC = 2'd2;
  localparam S_PLL  = 2'd3;

  reg  [1:0]  state;
  reg  [15:0] instr;
  reg         skip_next;
  reg         set_enable;
  reg         ce_pending;
  reg         wrap_fault;
  reg  [2:0]  ctrl;
  reg  [2:0]  pll_step;
  reg  [15:0] n_words;
  reg         nf_bit;
  reg  [3:0]  cw_word;
  reg  [22:0] tick_cnt;
  reg         ce_s1;
  reg         ce_s2;
  reg         ce_s3;

  wire [10:0] instruction_address_counter;
  wire [3:0]  op;
  wire [3:0]  ram_rdata;
  wire [11:0] stack_top;
  wire [1:0]  stack_depth;
  wire        run;
  wire        tick;
  wire        ce_rise;
  wire        in_exec;
  wire [10:0] seq_pc;
  wire [4:0]  ads_sum;

  reg  [5:0]  ram_rd_addr;
  reg  [10:0] next_target;
  reg         next_skip;
  reg         do_push;
  reg         do_pop;
  reg  [11:0] push_data;
  reg         ram_we;
  reg  [5:0]  ram_waddr;
  reg  [3:0]  ram_wdata;
  reg         take_int;
  reg         ttm_clear;
  reg         halt_set;
  reg         go_halt;
  reg         go_pll;
  reg         restart;

  assign instruction_address_counter = prog_addr_o;
  assign op      = instr[15:12];
  assign run     = ctrl[`CTRL_RUN_BIT];
  assign in_exec = run && !halted_o && state == S_EXEC;
  assign tick    = tick_cnt == TICK_CYCLES - 1;
  assign ce_rise = ce_s2 && !ce_s3;
  assign ads_sum = {1'b0, ram_rdata} + {1'b0, instr[9:6]};
  // Fetch past the last program word wraps to the start
  assign seq_pc  = (instruction_address_counter == `PROG_LAST) ? `RESET_VECTOR :
                   instruction_address_counter + 11'h001;

  seq_stack #(
    .DEPTH(`STACK_DEPTH),
    .WIDTH(`STACK_W)
  ) u_stack (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (clk_en_i),
    .push_i     (do_push),
    .pop_i      (do_pop),
    .push_data_i(push_data),
    .top_o      (stack_top),
    .depth_o    (stack_depth)
  );

  seq_data_ram #(
    .WORDS(`RAM_WORDS),
    .AW   (`RAM_AW),
    .DW   (`RAM_DW)
  ) u_ram (
    .ref_clk_i(ref_clk_i),
    .rst_n_i  (rst_n_i),
    .en_i     (clk_en_i),
    .rd_addr_i(ram_rd_addr),
    .wr_en_i  (ram_we),
    .wr_addr_i(ram_waddr),
    .wr_data_i(ram_wdata),
    .rd_data_o(ram_rdata)
  );

  // Divide-ratio gather order, then reference select word
  always @* begin
    ram_rd_addr = prog_data_i[5:0];
    if (state == S_PLL) begin
      case (pll_step)
        3'd0:    ram_rd_addr = `N_WORD0;
        3'd1:    ram_rd_addr = `N_WORD1;
        3'd2:    ram_rd_addr = `N_WORD2;
        3'd3:    ram_rd_addr = `N_WORD3;
        3'd4:    ram_rd_addr = {2'b00, instr[3:0]};
        default: ram_rd_addr = instr[9:4];
      endcase
    end
  end

  // Execute-stage decisions
  always @* begin
    next_target = seq_pc;
    next_skip   = 1'b0;
    do_push     = 1'b0;
    do_pop      = 1'b0;
    push_data   = {1'b0, seq_pc};
    ram_we      = 1'b0;
    ram_waddr   = instr[5:0];
    ram_wdata   = instr[9:6];
    take_int    = 1'b0;
    ttm_clear   = 1'b0;
    halt_set    = 1'b0;
    go_halt     = 1'b0;
    go_pll      = 1'b0;
    if (in_exec && !skip_next) begin
      case (op)
        `OP_ADS: begin
          ram_we    = 1'b1;
          ram_wdata = ads_sum[3:0];
          next_skip = ads_sum[4];
        end
        `OP_BRANCH_P0: next_target = {1'b0, instr[9:0]};
        `OP_BRANCH_P1: next_target = {1'b1, instr[9:0]};
        `OP_CALL: begin
          do_push     = 1'b1;
          next_target = {1'b0, instr[9:0]};
        end
        `OP_RET: begin
          do_pop      = 1'b1;
          next_target = stack_top[10:0];
          next_skip   = stack_top[`STACK_SKIP_BIT];
        end
        `OP_RET_SKIP: begin
          do_pop      = 1'b1;
          next_target = stack_top[10:0];
          next_skip   = 1'b1;
        end
        `OP_TMT: next_skip = (ram_rdata & instr[9:6]) == instr[9:6];
        `OP_TTM: begin
          ttm_clear = 1'b1;
          next_skip = timer_flag_o;
        end
        `OP_HALT: begin
          halt_set = 1'b1;
          go_halt  = !ce_s2;
        end
        `OP_PLL: go_pll = 1'b1;
        `OP_LOAD: ram_we = 1'b1;
        default: next_target = seq_pc;
      endcase
    end
    // Interrupt saves the flow that would have followed, skip decision included
    if (in_exec && int_req_i && ctrl[`CTRL_INTEN_BIT] && !do_push && !do_pop &&
        !go_pll && !go_halt) begin
      take_int  = 1'b1;
      do_push   = 1'b1;
      push_data = {next_skip, next_target};
    end
  end

  // Clear wins over a coinciding tick, so the restart waits another period
  always @* begin
    restart = ce_pending && tick && !ttm_clear;
  end

  // Chip enable pin synchroniser and edge detect
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ce_s1 <= 1'b0;
      ce_s2 <= 1'b0;
      ce_s3 <= 1'b0;
    end else if (clk_en_i) begin
      ce_s1 <= chip_enable_pin_i;
      ce_s2 <= ce_s1;
      ce_s3 <= ce_s2;
    end
  end

  // Periodic tick divider
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 23'h00_0000;
    end else if (clk_en_i) begin
      if (tick) begin
        tick_cnt <= 23'h00_0000;
      end else begin
        tick_cnt <= tick_cnt + 23'h00_0001;
      end
    end
  end

  // Timer flag and restart bookkeeping
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_flag_o <= 1'b0;
      set_enable   <= 1'b0;
      ce_pending   <= 1'b0;
    end else if (clk_en_i) begin
      if (ttm_clear) begin
        timer_flag_o <= 1'b0;
        set_enable   <= 1'b1;
      end else if (halt_set) begin
        timer_flag_o <= 1'b1;
      end else if (tick && (set_enable || ce_pending)) begin
        timer_flag_o <= 1'b1;
      end
      if (ce_rise) begin
        ce_pending <= 1'b1;
      end else if (restart) begin
        ce_pending <= 1'b0;
      end
    end
  end

  // Sequencer
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state        <= S_ADDR;
      prog_addr_o  <= `RESET_VECTOR;
      instr        <= 16'h0000;
      skip_next    <= 1'b0;
      halted_o     <= 1'b0;
      int_ack_o    <= 1'b0;
      wrap_fault   <= 1'b0;
      pll_step     <= 3'd0;
      n_words      <= 16'h0000;
      nf_bit       <= 1'b0;
      cw_word      <= 4'h0;
      pll_divide_o <= 17'h0_0000;
      pll_ref_sel_o <= 4'h0;
      pll_load_o   <= 1'b0;
    end else if (clk_en_i) begin
      int_ack_o  <= 1'b0;
      pll_load_o <= 1'b0;
      if (restart) begin
        state       <= S_ADDR;
        prog_addr_o <= `RESET_VECTOR;
        skip_next   <= 1'b0;
        halted_o    <= 1'b0;
      end else if (run && !halted_o) begin
        case (state)
          S_ADDR: state <= S_DEC;
          S_DEC: begin
            instr <= prog_data_i;
            state <= S_EXEC;
          end
          S_EXEC: begin
            if (take_int) begin
              prog_addr_o <= `INT_VECTOR;
              skip_next   <= 1'b0;
              int_ack_o   <= 1'b1;
              state       <= S_ADDR;
            end else if (go_pll) begin
              pll_step <= 3'd0;
              state    <= S_PLL;
            end else begin
              prog_addr_o <= next_target;
              skip_next   <= next_skip;
              halted_o    <= go_halt;
              state       <= S_ADDR;
              if (instruction_address_counter == `PROG_LAST && next_target == seq_pc) begin
                wrap_fault <= 1'b1;
              end
            end
          end
          S_PLL: begin
            pll_step <= pll_step + 3'd1;
            case (pll_step)
              3'd1: n_words[3:0]   <= ram_rdata;
              3'd2: n_words[7:4]   <= ram_rdata;
              3'd3: n_words[11:8]  <= ram_rdata;
              3'd4: n_words[15:12] <= ram_rdata;
              3'd5: nf_bit         <= ram_rdata[3];
              default: cw_word     <= ram_rdata;
            endcase
            if (pll_step == 3'd6) begin
              pll_divide_o <= {n_words, nf_bit};
              // Select word sharing the extra-bit word is not taken
              if (instr[9:4] != {2'b00, instr[3:0]}) begin
                pll_ref_sel_o <= ram_rdata;
              end
              pll_load_o  <= 1'b1;
              prog_addr_o <= seq_pc;
              state       <= S_ADDR;
            end
          end
          default: state <= S_ADDR;
        endcase
      end
    end
  end

  // Port direction words
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_a_dir_o    <= 2'b00;
      port_b_out_en_o <= 1'b0;
      ctrl            <= `CTRL_RESET;
    end else if (clk_en_i) begin
      if (restart) begin
        port_a_dir_o    <= 2'b00;
        port_b_out_en_o <= 1'b0;
      end else begin
        if (ram_we && ram_waddr == `PORT_A_DIR_ADDR) begin
          port_a_dir_o <= ram_wdata[`PORT_A_DIR_HI:`PORT_A_DIR_LO];
        end
        if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
          port_b_out_en_o <= reg_wdata_i[`CTRL_PORTB_BIT];
        end
      end
      if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
        ctrl <= reg_wdata_i[2:0];
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `REG_CTRL:    reg_rdata_o <= {29'h0000_0000, port_b_out_en_o, ctrl[2], ctrl[0]};
          `REG_PC:      reg_rdata_o <= {21'h00_0000, instruction_address_counter};
          `REG_STATUS:  reg_rdata_o <= {25'h000_0000, stack_depth, wrap_fault, ce_pending,
                                        halted_o, set_enable, timer_flag_o};
          `REG_PLL_DIV: reg_rdata_o <= {15'h0000, pll_divide_o};
          `REG_PLL_REF: reg_rdata_o <= {28'h000_0000, pll_ref_sel_o};
          default:      reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== logic/tuner_seq_defines.vh ====
// Constants for the tuning controller sequencing core
// Functional notes
// - The 11-bit instruction address counter steps by one per executed instruction.
// - Branch and call load the counter with the operand target address.
// - Skip instructions advance normally; a true skip turns the next one into a no-op.
// - An accepted interrupt forces the counter to address 1.
// - Three 12-bit stack entries: return address plus interrupt skip decision.
// - Both return instructions pop the top entry into the counter.
// - Program store is 16 bits by 1,526 words, addresses 000H to 5F5H.
// - Page zero spans 000H-3FFH, page one spans 400H-5F5H.
// - Calls can only target page zero; returns may sit in either page.
// - Branch code 06 targets page zero, 02 targets page one relative to 400H.
// - Data memory is 64 words of 4 bits; 00H-0FH are general registers.
// - Divide ratio uses words 00H, 10H, 20H, 30H plus a register's top bit.
// - Reference select word, not the extra-bit word, loads with divide bits at once.
// - Upper two bits of word 1FH set port A pin directions.
// - Timer flag set every 125 ms, cleared only by the timer test, which reports it.
// - Power-on clears the timer flag; halt or rising chip enable sets it.
// - Power-on starts at 0 with flag clear; periodic set blocked until first timer test.
// - Rising chip enable restarts at 0 when the flag next sets.
// - A timer test coinciding with a set keeps restart pending until next set.
// - Rising chip enable resets, restarts at zero and returns ports to input.
`ifndef TUNER_SEQ_DEFINES_VH
`define TUNER_SEQ_DEFINES_VH

`define REF_CLK_HZ      20000000
`define TIMER_TICK_MS   125
`define TIMER_TICK_CYC  (`TIMER_TICK_MS * (`REF_CLK_HZ / 1000))

`define PC_W            11
`define PROG_LAST       11'h5f5
`define PAGE_ONE_BIT    10
`define INT_VECTOR      11'h001
`define RESET_VECTOR    11'h000

`define STACK_DEPTH     3
`define STACK_W         12
`define STACK_SKIP_BIT  11

`define RAM_WORDS       64
`define RAM_AW          6
`define RAM_DW          4
`define N_WORD0         6'h00
`define N_WORD1         6'h10
`define N_WORD2         6'h20
`define N_WORD3         6'h30
`define PORT_A_DIR_ADDR 6'h1f
`define PORT_A_DIR_HI   3
`define PORT_A_DIR_LO   2

`define OP_ADS          4'h1
`define OP_BRANCH_P1    4'h2
`define OP_CALL         4'h3
`define OP_RET          4'h4
`define OP_RET_SKIP     4'h5
`define OP_BRANCH_P0    4'h6
`define OP_TMT          4'h7
`define OP_TTM          4'h8
`define OP_HALT         4'h9
`define OP_PLL          4'ha
`define OP_LOAD         4'hb

`define REG_CTRL        4'h0
`define REG_PC          4'h1
`define REG_STATUS      4'h2
`define REG_PLL_DIV     4'h3
`define REG_PLL_REF     4'h4
`define CTRL_RESET      3'h1
`define CTRL_RUN_BIT    0
`define CTRL_PORTB_BIT  1
`define CTRL_INTEN_BIT  2

`endif

// ==== logic/seq_stack.v ====
// Three-level return stack, top entry at index 0
`timescale 1ns/10ps
module seq_stack #(
  parameter DEPTH = 3,
  parameter WIDTH = 12
) (
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  input  wire             en_i,
  input  wire             push_i,
  input  wire             pop_i,
  input  wire [WIDTH-1:0] push_data_i,
  output wire [WIDTH-1:0] top_o,
  output reg  [1:0]       depth_o
);
  wire [WIDTH-1:0] entry [0:DEPTH];
  assign entry[DEPTH] = {WIDTH{1'b0}};
  assign top_o = entry[0];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : lvl
      reg  [WIDTH-1:0] slot;
      wire [WIDTH-1:0] upper;
      assign entry[g] = slot;
      // Push source: new word at the top, the level above elsewhere
      if (g == 0) begin : head
        assign upper = push_data_i;
      end else begin : body
        assign upper = entry[g-1];
      end
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          slot <= {WIDTH{1'b0}};
        end else if (en_i && push_i) begin
          slot <= upper;
        end else if (en_i && pop_i) begin
          slot <= entry[g+1];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      depth_o <= 2'h0;
    end else if (en_i && push_i && depth_o != DEPTH) begin
      depth_o <= depth_o + 2'h1;
    end else if (en_i && pop_i && depth_o != 2'h0) begin
      depth_o <= depth_o - 2'h1;
    end
  end
endmodule

// ==== logic/seq_data_ram.v ====
// Data memory, one write port and one registered read port
`timescale 1ns/10ps
module seq_data_ram #(
  parameter WORDS = 64,
  parameter AW    = 6,
  parameter DW    = 4
) (
  input  wire          ref_clk_i,
  input  wire          rst_n_i,
  input  wire          en_i,
  input  wire [AW-1:0] rd_addr_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  output reg  [DW-1:0] rd_data_o
);
  reg [DW-1:0] mem [0:WORDS-1];

  always @(posedge ref_clk_i) begin
    if (en_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= {DW{1'b0}};
    end else if (en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

// ==== verification/prog_rom_model.sv ====
// Synchronous program store model feeding the sequencer fetch port
`timescale 1ns/10ps
module prog_rom_model (
  input  wire        ref_clk_i,
  input  wire [10:0] addr_i,
  output reg  [15:0] data_o
);
  reg [15:0] mem [0:1525]; // 16 bits by 1,526 words

  initial data_o = 16'h0000;
  // Nothing answers past the last word, so the bus toggles
  always @(posedge ref_clk_i) begin
    if (addr_i <= 11'h5f5) begin
      data_o <= mem[addr_i];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule

// ==== verification/seq_timer_checker_sva.sv ====
// Port assertions for the sequencer and timer flag
`timescale 1ns/10ps
`include "tuner_seq_defines.vh"
module seq_timer_checker #(
  parameter TICK_CYCLES = 64
) (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        int_req_i,
  input wire [15:0] prog_data_i,
  input wire        reg_wr_i,
  input wire [10:0] prog_addr_o,
  input wire        int_ack_o,
  input wire [16:0] pll_divide_o,
  input wire [3:0]  pll_ref_sel_o,
  input wire        pll_load_o,
  input wire [1:0]  port_a_dir_o,
  input wire        port_b_out_en_o,
  input wire        timer_flag_o
);
  wire [3:0] op_field  = prog_data_i[15:12];
  wire [5:0] ram_field = prog_data_i[5:0];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  pc_step_a: assert property (
    ($changed(prog_addr_o) && prog_addr_o > 11'h001)
      |=> ($stable(prog_addr_o) || prog_addr_o <= 11'h001) [*2])
    else $error("counter stepped again too soon");
  pc_range_a: assert property (prog_addr_o <= 11'h5f5)
    else $error("counter beyond last program word");
  int_vector_a: assert property (int_ack_o |-> prog_addr_o == 11'h001)
    else $error("interrupt taken without vector one");
  int_cause_a: assert property ($rose(int_ack_o) |-> $past(int_req_i))
    else $error("interrupt taken without request");
  flag_clear_a: assert property ($fell(timer_flag_o) |-> $past(op_field) == `OP_TTM)
    else $error("timer flag cleared by another op");
  port_dir_a: assert property (
    ($changed(port_a_dir_o) && port_a_dir_o != 2'b00) |-> $past(ram_field) == 6'h1f)
    else $error("port A direction set from wrong word");
  pll_pair_a: assert property (
    ($changed(pll_divide_o) || $changed(pll_ref_sel_o))
      |-> (pll_load_o || $past(pll_load_o)) or (##1 pll_load_o))
    else $error("synthesizer words changed without transfer");
  restart_a: assert property (
    ($fell(port_b_out_en_o) && !$past(reg_wr_i) && !$past(reg_wr_i, 2))
      |-> prog_addr_o == 11'h000 && timer_flag_o)
    else $error("port release without restart");

  int_c: cover property (int_ack_o);
  pll_c: cover property (pll_load_o);
  restart_c: cover property ($rose(timer_flag_o) && prog_addr_o == 11'h000);
endmodule

bind tuner_cpu_sequencer_timer seq_timer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .ref_clk_i       (ref_clk_i),
  .rst_n_i         (rst_n_i),
  .int_req_i       (int_req_i),
  .prog_data_i     (prog_data_i),
  .reg_wr_i        (reg_wr_i),
  .prog_addr_o     (prog_addr_o),
  .int_ack_o       (int_ack_o),
  .pll_divide_o    (pll_divide_o),
  .pll_ref_sel_o   (pll_ref_sel_o),
  .pll_load_o      (pll_load_o),
  .port_a_dir_o    (port_a_dir_o),
  .port_b_out_en_o (port_b_out_en_o),
  .timer_flag_o    (timer_flag_o)
);

// ==== verification/tuner_cpu_sequencer_timer_tb.sv ====
// Self-checking bench for sequencing, stack, timer flag and restart
`timescale 1ns/10ps
`include "tuner_seq_defines.vh"
module tuner_cpu_sequencer_timer_tb;
  localparam TICK = 64;
  reg         ref_clk_i         = 1'b0;
  reg         rst_n_i           = 1'b0;
  reg         clk_en_i          = 1'b1;
  reg         chip_enable_pin_i = 1'b0;
  reg         int_req_i         = 1'b0;
  reg  [3:0]  reg_addr_i        = 4'h0;
  reg  [31:0] reg_wdata_i       = 32'h0000_0000;
  reg         reg_wr_i          = 1'b1; // Stop write, taken at reset release
  reg         reg_rd_i          = 1'b0;
  reg  [10:0] dc                = 11'h000;
  reg  [9:0]  ld [0:5]          = '{10'h080, 10'h0d0, 10'h120, 10'h170, 10'h203, 10'h188};
  reg  [31:0] rd;
  wire [15:0] prog_data;
  wire [31:0] reg_rdata_o;
  wire [10:0] prog_addr_o;
  wire [16:0] pll_divide_o;
  wire [3:0]  pll_ref_sel_o;
  wire [1:0]  port_a_dir_o;
  wire        int_ack_o, pll_load_o, port_b_out_en_o, timer_flag_o, halted_o;
  integer     miscompares       = 0;
  integer     samples_checked   = 0;
  integer     cycles            = 0;
  integer     i, n;

  tuner_cpu_sequencer_timer #(.TICK_CYCLES(TICK)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .chip_enable_pin_i(chip_enable_pin_i), .int_req_i(int_req_i), .prog_data_i(prog_data),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .prog_addr_o(prog_addr_o),
    .int_ack_o(int_ack_o), .pll_divide_o(pll_divide_o), .pll_ref_sel_o(pll_ref_sel_o),
    .pll_load_o(pll_load_o), .port_a_dir_o(port_a_dir_o),
    .port_b_out_en_o(port_b_out_en_o), .timer_flag_o(timer_flag_o), .halted_o(halted_o)
  );
  prog_rom_model rom (.ref_clk_i(ref_clk_i), .addr_i(prog_addr_o), .data_o(prog_data));

  always #25 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end

  function [15:0] op(input [3:0] o, input [9:0] f);
    op = {o, 2'b00, f};
  endfunction

  task check(input string nm, input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task reg_write(input [3:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task reg_read(input [3:0] a, output [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task next_pc(input [10:0] e);
    reg [10:0] prev;
    prev = prog_addr_o;
    n = 0;
    while (prog_addr_o === prev && n < 40) begin
      @(posedge ref_clk_i);
      #1 n = n + 1;
    end
    check("prog_addr", {21'h0, e}, {21'h0, prog_addr_o | dc});
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    for (i = 0; i < 1526; i = i + 1) begin
      rom.mem[i] = 16'h0000;
    end
    rom.mem[11'h000] = op(`OP_BRANCH_P0, 10'h010);
    rom.mem[11'h001] = op(`OP_TTM, 10'h000);
    rom.mem[11'h002] = op(`OP_BRANCH_P0, 10'h100);
    rom.mem[11'h003] = op(`OP_RET, 10'h000);
    rom.mem[11'h010] = op(`OP_LOAD, {4'hc, 6'h1f});
    rom.mem[11'h011] = op(`OP_CALL, 10'h040);
    rom.mem[11'h040] = op(`OP_BRANCH_P1, 10'h1f5);
    rom.mem[11'h5f5] = op(`OP_RET, 10'h000);
    rom.mem[11'h012] = op(`OP_LOAD, {4'hf, 6'h05});
    rom.mem[11'h013] = op(`OP_ADS, {4'h1, 6'h05});
    rom.mem[11'h014] = op(`OP_BRANCH_P0, 10'h100);
    rom.mem[11'h015] = op(`OP_ADS, {4'h1, 6'h05});
    rom.mem[11'h016] = op(`OP_TMT, {4'h1, 6'h05});
    rom.mem[11'h017] = op(`OP_BRANCH_P0, 10'h100);
    for (i = 0; i < 6; i = i + 1) begin
      rom.mem[11'h018 + i] = op(`OP_LOAD, ld[i]);
    end
    rom.mem[11'h01e] = op(`OP_PLL, {6'h08, 4'h3});
    rom.mem[11'h01f] = op(`OP_TTM, 10'h000);
    rom.mem[11'h020] = op(`OP_BRANCH_P0, 10'h021);
    rom.mem[11'h021] = op(`OP_BRANCH_P0, 10'h020);
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    repeat (2 * TICK + 12) @(posedge ref_clk_i);
    reg_read(4'h2, rd);
    check("status", 32'h0000_0000, rd);
    check("timer_flag", 1'b0, timer_flag_o);
    reg_read(4'hf, rd);
    check("unmapped", 32'h0000_0000, rd);
    reg_write(4'h0, 32'h0000_0005);
    next_pc(11'h010);
    next_pc(11'h011);
    next_pc(11'h040);
    next_pc(11'h5f5);
    for (i = 18; i <= 33; i = i + 1) begin
      next_pc(i[10:0]);
    end
    check("pll_divide", 17'h0_a865, pll_divide_o);
    check("pll_ref", 4'h6, pll_ref_sel_o);
    check("port_a_dir", 2'b11, port_a_dir_o);
    reg_read(4'h2, rd);
    check("status", 32'h0000_0002, rd & 32'h0000_0062);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    #1 rd = {21'h0, prog_addr_o};
    repeat (9) @(posedge ref_clk_i);
    #1 check("frozen_pc", rd, {21'h0, prog_addr_o});
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    n = 0;
    while (timer_flag_o !== 1'b1 && n < TICK + 8) begin
      @(posedge ref_clk_i);
      #1 n = n + 1;
    end
    check("timer_flag", 1'b1, timer_flag_o);
    @(posedge ref_clk_i);
    int_req_i <= 1'b1;
    n = 0;
    while (int_ack_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1 n = n + 1;
    end
    check("int_vector", 11'h001, prog_addr_o);
    @(posedge ref_clk_i);
    int_req_i <= 1'b0;
    next_pc(11'h002);
    check("timer_flag", 1'b0, timer_flag_o);
    next_pc(11'h003);
    dc = 11'h001;
    next_pc(11'h021);
    dc = 11'h000;
    reg_write(4'h0, 32'h0000_0003);
    chip_enable_pin_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 check("port_b_en", 1'b1, port_b_out_en_o);
    n = 0;
    while (prog_addr_o !== 11'h000 && n < TICK + 16) begin
      @(posedge ref_clk_i);
      #1 n = n + 1;
    end
    check("restart_pc", 11'h000, prog_addr_o);
    check("timer_flag", 1'b1, timer_flag_o);
    check("port_a_dir", 2'b00, port_a_dir_o);
    check("port_b_en", 1'b0, port_b_out_en_o);
    check("halted", 1'b0, halted_o);
    next_pc(11'h010);
    tally_and_finish;
  end
endmodule
